// ### src/ggrb_pkg.sv
// constants, register map and field layout of the gauge register bank
package ggrb_pkg;
   // register addresses (seven-bit command address field)
   localparam logic [6:0] ADDR_TEMPERATURE_AND_GAUGE = 7'h02;
   localparam logic [6:0] ADDR_CHARGE_COUNT_HIGH = 7'h03;
   localparam logic [6:0] ADDR_PACK_IDENTITY = 7'h04;
   localparam logic [6:0] ADDR_FULL_CAPACITY = 7'h05;
   localparam logic [6:0] ADDR_SECONDARY_FLAGS = 7'h06;
   localparam logic [6:0] ADDR_PULLDOWN_STRAPS = 7'h07;
   localparam logic [6:0] ADDR_PULLUP_STRAPS = 7'h08;
   localparam logic [6:0] ADDR_CHARGE_CYCLE_COUNT = 7'h09;
   localparam logic [6:0] ADDR_FILTER_THRESHOLD = 7'h0a;
   localparam logic [6:0] ADDR_CELL_VOLTAGE = 7'h0b;
   localparam logic [6:0] ADDR_EMPTY_THRESHOLD = 7'h0c;
   localparam logic [6:0] ADDR_CHARGE_COUNT_LOW = 7'h17;
   // reset values and cycle counter limits
   localparam logic [7:0] EMPTY_THRESHOLD_RESET = 8'h70;
   localparam logic [7:0] CHARGE_COUNT_RESET = 8'h00;
   localparam logic [7:0] FILTER_THRESHOLD_RESET = 8'h0a;
   localparam logic [7:0] CYCLE_COUNT_MAX = 8'hff;
   localparam logic [7:0] CYCLE_COUNT_STALE = 8'h40;
   // 100 mV at 2.4 V / 256 per code is 10.67 codes, taken as 11
   localparam logic [7:0] FINAL_WARNING_OFFSET = 8'h0b;
   // temperature codes: 0 C boundary, -20 C boundary
   localparam logic [3:0] TEMP_CODE_ZERO_C = 4'h4;
   localparam logic [3:0] TEMP_CODE_MINUS_20_C = 4'h2;
   // secondary flag fields
   localparam int FAST_CHARGE_BIT = 7;
   localparam int RATE_CODE_LSB = 4;
   localparam int OVERLOAD_BIT = 0;
   localparam logic [2:0] RATE_CODE_LOW = 3'h0;
   localparam logic [2:0] RATE_CODE_HIGH = 3'h1;
   // strap bits 1..6 in bits 5..0
   localparam int STRAP_WIDTH = 6;
   // fast charge ends below this count per second
   localparam logic [7:0] FAST_RATE_MIN = 8'h02;
   // self-discharge limit for a capacity update
   localparam logic [12:0] SELF_DISCHARGE_LIMIT = 13'h1000;
   // timing
   localparam int CLOCK_HZ = 125_000_000;
   localparam int SECOND_CYCLES = CLOCK_HZ;
   typedef enum logic [1:0] {GGRB_CMD, GGRB_DATA_IN, GGRB_DATA_OUT}
      ggrb_state_type;
endpackage

// ### src/ggrb_gauge_register_bank.sv
// gauge register bank: serial command port and charge bookkeeping
// Functional notes
// - empty threshold resets to 70h
// - empty threshold sets first warning voltage
// - final warning fixed 100mV below first
// - cell voltage register refreshed once per second
// - upper nibble is 10-degree temperature code
// - lower nibble is gauge in sixteenths
// - gauge scaled by temperature band, hysteresis
// - charge counter counts charge and discharge
// - counter clears on reset, charge after empty; other charge starts clear low byte
// - pack identity is free scratch storage
// - full reference loads programmed count, measured
// - fast charge flag set, drops below 2/s
// - rate code 001 below -150mV
// - overload sets below -250mV, clears -150mV
// - overload suspends end-of-discharge sampling
// - pull-down straps reported in bits 1-6
// - pull-up straps reported in bits 1-6
// - cycle counter counts charges, once above 0.94
// - cycle counter saturates, stale flag at 64
// - capacity update clears cycle counter, stale
// - update only after clean full discharge
// - magnitude filter register sets thresholds
// - command bit 7 write, 7-bit address
// - serial transfers least significant bit first
`timescale 1ns/1ps
`default_nettype none
module ggrb_gauge_register_bank
   import ggrb_pkg::*;
#(
   parameter int SECOND_COUNT = SECOND_CYCLES,
   parameter logic [7:0] PROGRAMMED_FULL_COUNT = 8'h80
) (
   // clock and reset
   input wire logic mclk_i,
   input wire logic reset_n_i,
   // serial port, one bit per strobe, lsb first
   input wire logic serial_bit_valid_i,
   input wire logic serial_bit_i,
   input wire logic serial_bit_ready_i,
   output logic serial_bit_valid_o,
   output logic serial_bit_o,
   // measurements from the analog front end
   input wire logic [7:0] cell_voltage_sample_i,
   input wire logic [3:0] temperature_code_i,
   input wire logic charge_count_tick_i,
   input wire logic discharge_count_tick_i,
   input wire logic self_discharge_tick_i,
   input wire logic sense_below_150mv_i,
   input wire logic sense_below_250mv_i,
   input wire logic [STRAP_WIDTH-1:0] pulldown_strap_bits_i,
   input wire logic [STRAP_WIDTH-1:0] pullup_strap_bits_i,
   // status toward the rest of the device
   output logic [7:0] empty_threshold_select_o,
   output logic [7:0] final_empty_warning_o,
   output logic [7:0] magnitude_filter_setting_o,
   output logic first_empty_warning_o,
   output logic gauge_stale_flag_o,
   output logic cell_sample_enable_o
);
   import ggrb_pkg::*;

   // ----------------------------------------------------------------
   // serial command port
   // ----------------------------------------------------------------
   ggrb_state_type state;
   logic [7:0] shift;
   logic [2:0] bit_count;
   logic [6:0] address;
   logic host_write;
   logic valid_write;

   logic [7:0] empty_threshold;
   logic [7:0] cell_voltage;
   logic [7:0] pack_identity;
   logic [7:0] full_capacity;
   logic [7:0] filter_threshold;
   logic [7:0] charge_cycle_count;
   logic [15:0] available_charge_count;
   logic [7:0] secondary_flag_byte;
   logic [3:0] gauge_fraction;
   logic fast_charge_flag;
   logic overload_flag;
   logic gauge_stale_flag;
   logic first_empty_warning;
   logic cold_band;
   logic [31:0] second_count;
   logic second_tick;
   logic charging;
   logic full_seen;
   logic discharge_clean;
   logic [12:0] self_discharge_count;
   logic [7:0] charge_rate_count;
   logic cycle_armed;
   logic capacity_update;

   always_ff @(posedge mclk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         state <= GGRB_CMD;
         shift <= 8'h00;
         bit_count <= 3'h0;
         address <= 7'h00;
         host_write <= 1'b0;
      end else begin
         unique case (state)
            GGRB_CMD, GGRB_DATA_IN: begin
               if (serial_bit_valid_i) begin
                  shift <= {serial_bit_i, shift[7:1]};
                  bit_count <= bit_count + 3'h1;
                  if (bit_count == 3'h7) begin
                     if (state == GGRB_CMD) begin
                        address <= shift[7:1];
                        host_write <= serial_bit_i;
                        if (serial_bit_i) begin
                           state <= GGRB_DATA_IN;
                        end else begin
                           state <= GGRB_DATA_OUT;
                           shift <= read_data_of(shift[7:1]);
                        end
                     end else begin
                        state <= GGRB_CMD;
                     end
                  end
               end
            end
            GGRB_DATA_OUT: begin
               if (serial_bit_ready_i) begin
                  shift <= {1'b0, shift[7:1]};
                  bit_count <= bit_count + 3'h1;
                  if (bit_count == 3'h7) begin
                     state <= GGRB_CMD;
                  end
               end
            end
         endcase
      end
   end

   assign serial_bit_valid_o = (state == GGRB_DATA_OUT);
   assign serial_bit_o = shift[0];
   // complete data byte for a write command
   assign valid_write = (state == GGRB_DATA_IN) && serial_bit_valid_i &&
      (bit_count == 3'h7) && host_write;
   logic [7:0] write_data;
   assign write_data = {serial_bit_i, shift[7:1]};

   function automatic logic [7:0] read_data_of(input logic [6:0] a);
      unique case (a)
         ADDR_TEMPERATURE_AND_GAUGE:
            read_data_of = {temperature_code_i, gauge_fraction};
         ADDR_CHARGE_COUNT_HIGH: read_data_of = available_charge_count[15:8];
         ADDR_CHARGE_COUNT_LOW: read_data_of = available_charge_count[7:0];
         ADDR_PACK_IDENTITY: read_data_of = pack_identity;
         ADDR_FULL_CAPACITY: read_data_of = full_capacity;
         ADDR_SECONDARY_FLAGS: read_data_of = secondary_flag_byte;
         ADDR_PULLDOWN_STRAPS: read_data_of = {2'b00, pulldown_strap_bits_i};
         ADDR_PULLUP_STRAPS: read_data_of = {2'b00, pullup_strap_bits_i};
         ADDR_CHARGE_CYCLE_COUNT: read_data_of = charge_cycle_count;
         ADDR_FILTER_THRESHOLD: read_data_of = filter_threshold;
         ADDR_CELL_VOLTAGE: read_data_of = cell_voltage;
         ADDR_EMPTY_THRESHOLD: read_data_of = empty_threshold;
         default: read_data_of = 8'h00;
      endcase
   endfunction

   // ----------------------------------------------------------------
   // host-writable settings
   // ----------------------------------------------------------------
   always_ff @(posedge mclk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         empty_threshold <= EMPTY_THRESHOLD_RESET;
         filter_threshold <= FILTER_THRESHOLD_RESET;
      end else if (valid_write) begin
         if (address == ADDR_EMPTY_THRESHOLD) begin
            empty_threshold <= write_data;
         end
         if (address == ADDR_FILTER_THRESHOLD) begin
            filter_threshold <= write_data;
         end
      end
   end

   // scratch byte has no defined reset and steers nothing
   always_ff @(posedge mclk_i) begin
      if (valid_write && address == ADDR_PACK_IDENTITY) begin
         pack_identity <= write_data;
      end
   end

   assign empty_threshold_select_o = empty_threshold;
   // saturate so a low threshold does not wrap to a high one
   assign final_empty_warning_o = (empty_threshold > FINAL_WARNING_OFFSET) ?
      empty_threshold - FINAL_WARNING_OFFSET : 8'h00;
   assign magnitude_filter_setting_o = filter_threshold;

   // ----------------------------------------------------------------
   // once-per-second sampling of the cell voltage
   // ----------------------------------------------------------------
   always_ff @(posedge mclk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         second_count <= 32'h0;
         second_tick <= 1'b0;
      end else begin
         second_tick <= (second_count == 32'(SECOND_COUNT - 1));
         second_count <= (second_count == 32'(SECOND_COUNT - 1)) ?
            32'h0 : second_count + 32'h1;
      end
   end

   assign cell_sample_enable_o = !overload_flag;

   always_ff @(posedge mclk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         cell_voltage <= 8'h00;
         first_empty_warning <= 1'b0;
      end else begin
         if (second_tick) begin
            cell_voltage <= cell_voltage_sample_i;
         end
         if (charging && charge_count_tick_i) begin
            first_empty_warning <= 1'b0;
         end else if (second_tick && !overload_flag &&
               cell_voltage_sample_i < empty_threshold) begin
            first_empty_warning <= 1'b1;
         end
      end
   end
   assign first_empty_warning_o = first_empty_warning;

   // ----------------------------------------------------------------
   // secondary flags
   // ----------------------------------------------------------------
   always_ff @(posedge mclk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         overload_flag <= 1'b0;
      end else if (sense_below_250mv_i) begin
         overload_flag <= 1'b1;
      end else if (!sense_below_150mv_i) begin
         overload_flag <= 1'b0;
      end
   end

   always_ff @(posedge mclk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         fast_charge_flag <= 1'b0;
         charge_rate_count <= 8'h00;
         charging <= 1'b0;
      end else begin
         if (discharge_count_tick_i) begin
            charging <= 1'b0;
         end else if (charge_count_tick_i) begin
            charging <= 1'b1;
         end
         if (charge_count_tick_i && !charging) begin
            fast_charge_flag <= 1'b1;
         end else if (second_tick) begin
            if (charge_rate_count < FAST_RATE_MIN) begin
               fast_charge_flag <= 1'b0;
            end
         end
         if (second_tick) begin
            charge_rate_count <= {7'h00, charge_count_tick_i};
         end else if (charge_count_tick_i && charge_rate_count != 8'hff) begin
            charge_rate_count <= charge_rate_count + 8'h01;
         end
      end
   end

   always_comb begin
      secondary_flag_byte = 8'h00;
      secondary_flag_byte[FAST_CHARGE_BIT] = fast_charge_flag;
      secondary_flag_byte[RATE_CODE_LSB +: 3] = sense_below_150mv_i ?
         RATE_CODE_HIGH : RATE_CODE_LOW;
      secondary_flag_byte[OVERLOAD_BIT] = overload_flag;
   end

   // ----------------------------------------------------------------
   // available charge counter
   // ----------------------------------------------------------------
   always_ff @(posedge mclk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         available_charge_count <= {CHARGE_COUNT_RESET, CHARGE_COUNT_RESET};
      end else if (charge_count_tick_i && !charging && first_empty_warning) begin
         available_charge_count <= {CHARGE_COUNT_RESET, CHARGE_COUNT_RESET};
      end else if (charge_count_tick_i && !charging) begin
         available_charge_count[7:0] <= CHARGE_COUNT_RESET;
      end else if (valid_write && address == ADDR_CHARGE_COUNT_HIGH) begin
         // host keeps this at or below the full reference
         available_charge_count[15:8] <= write_data;
      end else if (charge_count_tick_i) begin
         // efficiency correction is folded into the tick rate upstream
         if (available_charge_count != 16'hffff) begin
            available_charge_count <= available_charge_count + 16'h1;
         end
      end else if (discharge_count_tick_i || self_discharge_tick_i) begin
         if (available_charge_count != 16'h0000) begin
            available_charge_count <= available_charge_count - 16'h1;
         end
      end
   end

   // ----------------------------------------------------------------
   // gauge fraction with cold-temperature scaling
   // ----------------------------------------------------------------
   always_ff @(posedge mclk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         cold_band <= 1'b0;
      end else if (temperature_code_i < TEMP_CODE_ZERO_C - 4'h1) begin
         cold_band <= 1'b1;
      end else if (temperature_code_i >= TEMP_CODE_ZERO_C) begin
         cold_band <= 1'b0;
      end
   end

   always_comb begin
      logic [9:0] scaled;
      logic [9:0] raw;
      scaled = 10'h000;
      raw = (full_capacity == 8'h00) ? 10'h000 :
         10'(({available_charge_count[15:8], 4'h0}) / full_capacity);
      if (temperature_code_i < TEMP_CODE_MINUS_20_C) begin
         scaled = raw >> 1;
      end else if (cold_band) begin
         scaled = raw - (raw >> 2);
      end else begin
         scaled = raw;
      end
      gauge_fraction = (scaled > 10'h00f) ? 4'hf : scaled[3:0];
   end

   // ----------------------------------------------------------------
   // full reference update and cycle counting
   // ----------------------------------------------------------------
   assign capacity_update = first_empty_warning == 1'b0 && second_tick &&
      !overload_flag && cell_voltage_sample_i < empty_threshold &&
      full_seen && discharge_clean && temperature_code_i >= TEMP_CODE_ZERO_C &&
      self_discharge_count < SELF_DISCHARGE_LIMIT;

   always_ff @(posedge mclk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         full_seen <= 1'b0;
         discharge_clean <= 1'b0;
         self_discharge_count <= 13'h0000;
      end else begin
         if (available_charge_count[15:8] >= full_capacity &&
               !charge_count_tick_i) begin
            full_seen <= 1'b1;
            discharge_clean <= 1'b1;
            self_discharge_count <= 13'h0000;
         end else if (charge_count_tick_i && !charging) begin
            discharge_clean <= 1'b0;
         end else if (capacity_update) begin
            full_seen <= 1'b0;
         end
         if (self_discharge_tick_i && self_discharge_count != 13'h1fff) begin
            self_discharge_count <= self_discharge_count + 13'h0001;
         end
      end
   end

   always_ff @(posedge mclk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         full_capacity <= PROGRAMMED_FULL_COUNT;
      end else if (capacity_update) begin
         full_capacity <= full_capacity - available_charge_count[15:8];
      end else if (valid_write && address == ADDR_FULL_CAPACITY) begin
         full_capacity <= write_data;
      end
   end

   // 0.94 approximated as 15/16 of the full reference
   logic above_94;
   assign above_94 = {4'h0, available_charge_count[15:8]} >
      ({full_capacity, 4'h0} - {4'h0, full_capacity}) >> 4;

   always_ff @(posedge mclk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         charge_cycle_count <= 8'h00;
         gauge_stale_flag <= 1'b1;
         cycle_armed <= 1'b1;
      end else if (capacity_update) begin
         charge_cycle_count <= 8'h00;
         gauge_stale_flag <= 1'b0;
      end else if (charge_count_tick_i && !charging && cycle_armed) begin
         if (charge_cycle_count != CYCLE_COUNT_MAX) begin
            charge_cycle_count <= charge_cycle_count + 8'h01;
            if (charge_cycle_count + 8'h01 == CYCLE_COUNT_STALE) begin
               gauge_stale_flag <= 1'b1;
            end
         end
         cycle_armed <= !above_94;
      end else if (!above_94) begin
         cycle_armed <= 1'b1;
      end
   end
   assign gauge_stale_flag_o = gauge_stale_flag;
endmodule // ggrb_gauge_register_bank
`default_nettype wire

// ### tb/ggrb_monitor.sv
// concurrent checker on the gauge register bank ports
`timescale 1ns/1ps
`default_nettype none
module ggrb_monitor
   import ggrb_pkg::*;
(
   // clock, reset and serial port
   input wire logic mclk_i,
   input wire logic reset_n_i,
   input wire logic serial_bit_valid_i,
   input wire logic serial_bit_ready_i,
   input wire logic serial_bit_valid_o,
   input wire logic serial_bit_o,
   // sense levels and status
   input wire logic sense_below_150mv_i,
   input wire logic sense_below_250mv_i,
   input wire logic [7:0] empty_threshold_select_o,
   input wire logic [7:0] final_empty_warning_o,
   input wire logic [7:0] magnitude_filter_setting_o,
   input wire logic cell_sample_enable_o
);
   default clocking cb @(posedge mclk_i);
   endclocking
   default disable iff (!reset_n_i);
   // ----------
   // properties
   // ----------
   property p_final_offset;
      empty_threshold_select_o >= FINAL_WARNING_OFFSET |->
         final_empty_warning_o ==
         empty_threshold_select_o - FINAL_WARNING_OFFSET;
   endproperty
   a_final_offset: assert property (p_final_offset)
      else $error("final warning level off");
   property p_overload_set;
      sense_below_250mv_i [*3] |-> !cell_sample_enable_o;
   endproperty
   a_overload_set: assert property (p_overload_set)
      else $error("overload did not stop sampling");
   property p_overload_hold;
      !cell_sample_enable_o && sense_below_150mv_i |=> !cell_sample_enable_o;
   endproperty
   a_overload_hold: assert property (p_overload_hold)
      else $error("overload released too early");
   property p_overload_clear;
      !sense_below_150mv_i [*3] |-> cell_sample_enable_o;
   endproperty
   a_overload_clear: assert property (p_overload_clear)
      else $error("overload not cleared");
   property p_read_start;
      $rose(serial_bit_valid_o) |->
         $past(serial_bit_valid_i) || $past(serial_bit_valid_i, 2);
   endproperty
   a_read_start: assert property (p_read_start)
      else $error("read data without a command bit");
   property p_read_hold;
      serial_bit_valid_o && !serial_bit_ready_i |=>
         serial_bit_valid_o && $stable(serial_bit_o);
   endproperty
   a_read_hold: assert property (p_read_hold)
      else $error("read bit moved without a ready");
   property p_read_end;
      $fell(serial_bit_valid_o) |->
         $past(serial_bit_ready_i) || $past(serial_bit_ready_i, 2);
   endproperty
   a_read_end: assert property (p_read_end)
      else $error("read ended without a ready");
   property p_thr_write;
      !$stable(empty_threshold_select_o) |-> $past(serial_bit_valid_i);
   endproperty
   a_thr_write: assert property (p_thr_write)
      else $error("threshold changed without a write");
   property p_filter_write;
      !$stable(magnitude_filter_setting_o) |-> $past(serial_bit_valid_i);
   endproperty
   a_filter_write: assert property (p_filter_write)
      else $error("filter changed without a write");
endmodule // ggrb_monitor
`default_nettype wire

// ### tb/ggrb_host_model.sv
// host processor model for the serial command port
`timescale 1ns/1ps
`default_nettype none
module ggrb_host_model (
   // clock
   input wire logic mclk_i,
   // host to device
   output logic serial_bit_valid_o,
   output logic serial_bit_o,
   output logic serial_bit_ready_o,
   // device to host
   input wire logic serial_bit_valid_i,
   input wire logic serial_bit_i
);
   initial {serial_bit_valid_o, serial_bit_o, serial_bit_ready_o} = 3'h0;
   // ---------
   // transfers
   // ---------
   // entered just after an edge; an idle cycle closes every byte
   task automatic send_byte(input logic [7:0] b);
      for (int i = 0; i < 8; i++) begin
         serial_bit_valid_o <= 1'b1;
         serial_bit_o <= b[i];
         @(posedge mclk_i);
      end
      serial_bit_valid_o <= 1'b0;
      serial_bit_o <= ~b[7];
      @(posedge mclk_i);
   endtask
   task automatic write_reg(input logic [6:0] a, input logic [7:0] d);
      send_byte({1'b1, a});
      send_byte(d);
   endtask
   // gap plus one idles between bits, as a slow host
   task automatic read_reg(input logic [6:0] a, input int gap,
         output logic [7:0] d);
      int n;
      d = 8'hxx;
      n = 0;
      send_byte({1'b0, a});
      while (!serial_bit_valid_i && n < 20) begin
         @(posedge mclk_i);
         n++;
      end
      if (n < 20) begin
         for (int i = 0; i < 8; i++) begin
            d[i] = serial_bit_i;
            serial_bit_ready_o <= 1'b1;
            @(posedge mclk_i);
            serial_bit_ready_o <= 1'b0;
            repeat (gap + 1) @(posedge mclk_i);
         end
      end
   endtask
endmodule // ggrb_host_model
`default_nettype wire

// ### tb/tb_top.sv
// self-checking bench for the gauge register bank
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, gt) begin checks++; if ((gt) !== (ex)) begin fails++; \
   $display("MISMATCH %s expected %h seen %h", nm, ex, gt); end end
module tb_top;
   import ggrb_pkg::*;
   localparam int SEC = 16;
   localparam logic [7:0] FULL = 8'h80;
   localparam logic [3:0] TEMPS [5] = '{4'h6, 4'h0, 4'h2, 4'h3, 4'hc};
   int fails = 0;
   int checks = 0;
   int seed = 99234;
   logic mclk_i, reset_n_i, serial_bit_valid_i, serial_bit_i;
   logic serial_bit_ready_i, serial_bit_valid_o, serial_bit_o;
   logic charge_count_tick_i, discharge_count_tick_i, self_discharge_tick_i;
   logic sense_below_150mv_i, sense_below_250mv_i, first_empty_warning_o;
   logic gauge_stale_flag_o, cell_sample_enable_o;
   logic [7:0] cell_voltage_sample_i, empty_threshold_select_o;
   logic [7:0] final_empty_warning_o, magnitude_filter_setting_o;
   logic [3:0] temperature_code_i;
   logic [STRAP_WIDTH-1:0] pulldown_strap_bits_i, pullup_strap_bits_i;
   ggrb_gauge_register_bank #(.SECOND_COUNT(SEC), .PROGRAMMED_FULL_COUNT(FULL))
      DUT (.mclk_i, .reset_n_i, .serial_bit_valid_i, .serial_bit_i,
      .serial_bit_ready_i, .serial_bit_valid_o, .serial_bit_o,
      .cell_voltage_sample_i, .temperature_code_i, .charge_count_tick_i,
      .discharge_count_tick_i, .self_discharge_tick_i, .sense_below_150mv_i,
      .sense_below_250mv_i, .pulldown_strap_bits_i, .pullup_strap_bits_i,
      .empty_threshold_select_o, .final_empty_warning_o,
      .magnitude_filter_setting_o, .first_empty_warning_o,
      .gauge_stale_flag_o, .cell_sample_enable_o);
   ggrb_host_model host (.mclk_i, .serial_bit_valid_o(serial_bit_valid_i),
      .serial_bit_o(serial_bit_i), .serial_bit_ready_o(serial_bit_ready_i),
      .serial_bit_valid_i(serial_bit_valid_o), .serial_bit_i(serial_bit_o));
   initial begin
      mclk_i = 1'b0;
      forever #4 mclk_i = ~mclk_i;
   end
   // --------------------
   // helpers and verdict
   // --------------------
   // gauge for a count of 40h in each band
   function automatic logic [3:0] exp_gauge(input logic [3:0] t);
      int g;
      g = 8'h40 * 16 / FULL;
      if (t < TEMP_CODE_MINUS_20_C) g = g / 2;
      else if (t < TEMP_CODE_ZERO_C) g = g * 3 / 4;
      return 4'(g);
   endfunction
   task automatic rd_chk(input logic [6:0] a, input logic [7:0] ex,
         input string nm);
      logic [7:0] d;
      host.read_reg(a, $random(seed) & 3, d);
      `CHK(nm, ex, d)
   endtask
   task automatic sense(input logic [1:0] s, input logic [7:0] ex,
         input string nm);
      {sense_below_150mv_i, sense_below_250mv_i} <= s;
      repeat (4) @(posedge mclk_i);
      rd_chk(ADDR_SECONDARY_FLAGS, ex, nm);
   endtask
   task automatic close_out;
      if (fails == 0 && checks > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   initial begin
      repeat (40000) @(posedge mclk_i);
      fails++;
      close_out;
   end
   // -------------
   // main sequence
   // -------------
   initial begin
      logic [7:0] v;
      reset_n_i = 1'b0;
      {charge_count_tick_i, discharge_count_tick_i} = 2'h0;
      {self_discharge_tick_i, sense_below_150mv_i, sense_below_250mv_i} = 3'h0;
      cell_voltage_sample_i = 8'hff;
      temperature_code_i = 4'h6;
      {pulldown_strap_bits_i, pullup_strap_bits_i} = '0;
      repeat (6) @(posedge mclk_i);
      reset_n_i <= 1'b1;
      @(posedge mclk_i);
      rd_chk(ADDR_EMPTY_THRESHOLD, 8'h70, "thr_reset");
      rd_chk(ADDR_FILTER_THRESHOLD, 8'h0a, "filt_reset");
      rd_chk(ADDR_CHARGE_COUNT_HIGH, 8'h00, "available_charge_high_reset");
      rd_chk(ADDR_CHARGE_COUNT_LOW, 8'h00, "available_charge_low_reset");
      rd_chk(ADDR_FULL_CAPACITY, FULL, "full_reset");
      rd_chk(ADDR_CHARGE_CYCLE_COUNT, 8'h00, "cpi_reset");
      `CHK("fin_reset", 8'h65, final_empty_warning_o)
      `CHK("stale_reset", 1'b1, gauge_stale_flag_o)
      `CHK("warn_reset", 1'b0, first_empty_warning_o)
      for (int i = 0; i < 4; i++) begin
         v = 8'($random(seed));
         host.write_reg(ADDR_PACK_IDENTITY, v);
         rd_chk(ADDR_PACK_IDENTITY, v, "pack_id");
         v = {2'b01, v[5:0]};
         host.write_reg(ADDR_EMPTY_THRESHOLD, v);
         rd_chk(ADDR_EMPTY_THRESHOLD, v, "thr");
         `CHK("thr_o", v, empty_threshold_select_o)
         `CHK("fin_o", 8'(v - 8'h0b), final_empty_warning_o)
         v = 8'($random(seed));
         host.write_reg(ADDR_FILTER_THRESHOLD, v);
         rd_chk(ADDR_FILTER_THRESHOLD, v, "filt");
         `CHK("filt_o", v, magnitude_filter_setting_o)
         pulldown_strap_bits_i <= v[5:0];
         pullup_strap_bits_i <= ~v[5:0];
         cell_voltage_sample_i <= {1'b1, v[6:0]};
         repeat (3 * SEC) @(posedge mclk_i);
         rd_chk(ADDR_PULLDOWN_STRAPS, {2'b00, v[5:0]}, "pulldown");
         rd_chk(ADDR_PULLUP_STRAPS, {2'b00, ~v[5:0]}, "pullup");
         rd_chk(ADDR_CELL_VOLTAGE, {1'b1, v[6:0]}, "cell");
      end
      host.write_reg(ADDR_CHARGE_CYCLE_COUNT, 8'hff);
      host.write_reg(7'h7f, 8'h5a);
      rd_chk(ADDR_CHARGE_CYCLE_COUNT, 8'h00, "cpi_ro");
      rd_chk(7'h7f, 8'h00, "unmapped");
      sense(2'h2, 8'h10, "rate_high");
      sense(2'h3, 8'h11, "overload");
      sense(2'h2, 8'h11, "overload_held");
      `CHK("sampling_off", 1'b0, cell_sample_enable_o)
      sense(2'h0, 8'h00, "overload_clr");
      `CHK("sampling_on", 1'b1, cell_sample_enable_o)
      host.write_reg(ADDR_CHARGE_COUNT_HIGH, 8'h40);
      rd_chk(ADDR_CHARGE_COUNT_HIGH, 8'h40, "available_charge_high");
      foreach (TEMPS[i]) begin
         temperature_code_i <= TEMPS[i];
         repeat (3 * SEC) @(posedge mclk_i);
         rd_chk(ADDR_TEMPERATURE_AND_GAUGE, {TEMPS[i], exp_gauge(TEMPS[i])},
            "temp_gauge");
      end
      for (int k = 1; k < 4; k++) begin
         charge_count_tick_i <= 1'b1;
         rd_chk(ADDR_SECONDARY_FLAGS, 8'h80, "fast_charge");
         rd_chk(ADDR_CHARGE_CYCLE_COUNT, 8'(k), "cycles");
         {charge_count_tick_i, discharge_count_tick_i} <= 2'h1;
         @(posedge mclk_i);
         discharge_count_tick_i <= 1'b0;
         @(posedge mclk_i);
      end
      close_out;
   end
endmodule // tb_top
bind ggrb_gauge_register_bank ggrb_monitor u_mon (.mclk_i,
   .reset_n_i, .serial_bit_valid_i, .serial_bit_ready_i, .serial_bit_valid_o,
   .serial_bit_o, .sense_below_150mv_i, .sense_below_250mv_i,
   .empty_threshold_select_o, .final_empty_warning_o,
   .magnitude_filter_setting_o, .cell_sample_enable_o);
`default_nettype wire
